// ---- verilog/sfl_pkg.sv ----
package sfl_pkg;
   localparam int NCAT = 6;
   localparam int CAT_W = 3;
   localparam int SLOT_W = 4;
   localparam logic [SLOT_W-1:0] SLOTS = 4'ha;
   localparam int VEC_W = 16;
   localparam int TOD_W = 32;
   localparam int AXI_AW = 8;
   localparam int LVL_W = 16;

   localparam logic [CAT_W-1:0] CAT_MOD = 3'h0;
   localparam logic [CAT_W-1:0] CAT_DEMOD = 3'h1;
   localparam logic [CAT_W-1:0] CAT_TX = 3'h2;
   localparam logic [CAT_W-1:0] CAT_RX = 3'h3;
   localparam logic [CAT_W-1:0] CAT_COM = 3'h4;
   localparam logic [CAT_W-1:0] CAT_UNAVL = 3'h5;

   localparam int MOD_W = 8;
   localparam int DEMOD_W = 6;
   localparam int TX_W = 7;
   localparam int RX_W = 8;
   localparam int COM_W = 4;
   localparam int PIN_W = MOD_W + DEMOD_W + TX_W + RX_W + COM_W + 2;

   localparam int RX_PATT_BIT = 8;
   localparam int RX_FILL_BIT = 9;
   localparam int COM_CTRL_BIT = 4;
   localparam int COM_IFACE_BIT = 5;
   localparam logic [VEC_W-1:0] PDOWN_VEC = 16'h4010;
   localparam logic [VEC_W-1:0] PUP_VEC = 16'h8010;
   localparam logic [1:0] IFACE_IDLE = 2'b11;

   localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] REG_SEL = 8'h04;
   localparam logic [AXI_AW-1:0] REG_ENT_TIME = 8'h08;
   localparam logic [AXI_AW-1:0] REG_ENT_VEC = 8'h0c;
   localparam logic [AXI_AW-1:0] REG_COUNTS = 8'h10;
   localparam logic [AXI_AW-1:0] REG_IRQ_ST = 8'h14;
   localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 8'h18;
   localparam logic [AXI_AW-1:0] REG_ALARMS = 8'h1c;

   localparam int CTRL_CLR_LOG = 0;
   localparam int CTRL_CLR_CTRLF = 1;
   localparam int CTRL_CHK_EN = 2;
   localparam int CTRL_FEC = 3;
   localparam int SEL_SLOT_LSB = 0;
   localparam int SEL_CAT_LSB = 8;
   localparam logic [NCAT-1:0] MASK_RST = 6'h00;

   localparam logic [31:0] RXBUF_DEPTH = 32'h0000_0400;
   localparam logic [31:0] FILL_LO_PCT = 32'h0000_000a;
   localparam logic [31:0] FILL_HI_PCT = 32'h0000_005a;
   localparam logic [31:0] PCT_FULL = 32'h0000_0064;

   localparam int CLK_HZ = 125_000_000;
   localparam int SECOND_S = 1;
   localparam int SEC_CYCLES = CLK_HZ * SECOND_S;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SFL_PDOWN = 2'b00,
      SFL_PUP = 2'b01,
      SFL_RUN = 2'b11
   } sfl_pwr_t;

   typedef struct packed {
      logic [TOD_W-1:0] tod;
      logic [VEC_W-1:0] vec;
   } sfl_entry_t;

   function automatic logic [31:0] sfl_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// ---- verilog/sfl_logger.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - each category keeps only its first ten entries; later ones dropped until cleared.
// - separate logs for modulator, demodulator, tx, rx and common categories.
// - each entry but the power-loss one stamped with time of day at detection.
// - reset empties all logs; only the retained last time survives.
// - after power-up, common slot 0 holds the retained power-loss time.
// - then common slot 1 holds the power-up time.
// - slots fill oldest first, slot 0 oldest, slot 9 newest.
// - unwritten slots read back as empty, no fault.
// - clear command discards all entries; recording restarts at slot 0.
// - reader selects category and slot, gets timestamp and fault vector.
// - buffer fill alarm when occupancy below 10% or above 90%.
// - pattern lock alarm when checker unlocked, suppressed while checker off.
// - with block coding fitted, log unavailable seconds with uncorrectable blocks.
// - common vector has controller flag, set after a power cycle.
// - common vector has interface module flag: absent or not programmable.
// - rx vector carries buffer, data, error rate, clock and lock flags.
// - modulator vector carries synthesizer, channel, level and reference flags.
module sfl_logger #(
   parameter int SEC_CYCLES = sfl_pkg::SEC_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [sfl_pkg::MOD_W-1:0] mod_fault,
   input wire logic [sfl_pkg::DEMOD_W-1:0] demod_fault,
   input wire logic [sfl_pkg::TX_W-1:0] tx_fault,
   input wire logic [sfl_pkg::RX_W-1:0] rx_fault,
   input wire logic [sfl_pkg::COM_W-1:0] common_fault,
   input wire logic iface_present,
   input wire logic iface_prog_ok,
   input wire logic [sfl_pkg::TOD_W-1:0] tod,
   input wire logic [sfl_pkg::TOD_W-1:0] nv_tod,
   input wire logic [sfl_pkg::LVL_W-1:0] rxbuf_level,
   input wire logic prbs_locked,
   input wire logic blk_uncorrectable,
   input wire logic [sfl_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sfl_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   import sfl_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [PIN_W-1:0] pins;
      sfl_pwr_t pwr;
      logic [TOD_W-1:0] retained;
      sfl_entry_t [NCAT-1:0][9:0] log;
      logic [NCAT-1:0][SLOT_W-1:0] cnt;
      logic [NCAT-1:0][VEC_W-1:0] prev;
      logic ctrl_fault;
      logic chk_en;
      logic fec_fit;
      logic [CAT_W-1:0] sel_cat;
      logic [SLOT_W-1:0] sel_slot;
      logic [NCAT-1:0] irq_st;
      logic [NCAT-1:0] irq_mask;
      logic [31:0] sec_cnt;
      logic err_sec;
      logic unavl;
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } sfl_state_t;

   sfl_state_t s;
   sfl_state_t next_s;

   logic [NCAT-1:0][VEC_W-1:0] vec;
   logic [NCAT-1:0] chg;
   logic [NCAT-1:0] rec;
   logic [NCAT-1:0][SLOT_W-1:0] base;
   logic fill_alarm;
   logic patt_alarm;
   logic tick;
   logic wr;
   logic clr_log;
   logic [31:0] lvl_pct;
   logic [31:0] sel_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] counts_reg;
   sfl_entry_t ent;
   logic [31:0] wm_ctrl;
   logic [31:0] wm_sel;
   logic [31:0] wm_clr;
   logic [31:0] wm_mask;

   // software cannot pick an entry beyond what has been written
   always_comb begin
      ent = '0;
      if (s.sel_cat < CAT_W'(NCAT) && s.sel_slot < s.cnt[s.sel_cat]) begin
         ent = s.log[s.sel_cat][s.sel_slot];
      end
   end

   always_comb begin
      lvl_pct = 32'(rxbuf_level) * PCT_FULL;
      fill_alarm = (lvl_pct < RXBUF_DEPTH * FILL_LO_PCT) ||
                   (lvl_pct > RXBUF_DEPTH * FILL_HI_PCT);
      patt_alarm = s.chk_en && !prbs_locked;
      tick = (s.sec_cnt == 32'(SEC_CYCLES - 1));
      wr = s.aw_got && s.w_got && !s.bvalid;
      clr_log = wr && (s.awaddr[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) &&
                s.wstrb[0] && s.wdata[CTRL_CLR_LOG];
      sel_reg = '0;
      sel_reg[SEL_SLOT_LSB +: SLOT_W] = s.sel_slot;
      sel_reg[SEL_CAT_LSB +: CAT_W] = s.sel_cat;
      ctrl_reg = '0;
      ctrl_reg[CTRL_CHK_EN] = s.chk_en;
      ctrl_reg[CTRL_FEC] = s.fec_fit;
      counts_reg = '0;
      for (int c = 0; c < NCAT; c++) begin
         counts_reg[c*SLOT_W +: SLOT_W] = s.cnt[c];
      end
      wm_ctrl = sfl_merge(ctrl_reg, s.wdata, s.wstrb);
      wm_sel = sfl_merge(sel_reg, s.wdata, s.wstrb);
      wm_clr = sfl_merge(32'h0, s.wdata, s.wstrb);
      wm_mask = sfl_merge(32'(s.irq_mask), s.wdata, s.wstrb);
   end

   // vector assembly from the settled pin image
   always_comb begin
      vec = '0;
      vec[CAT_MOD][MOD_W-1:0] = s.pins[0 +: MOD_W];
      vec[CAT_DEMOD][DEMOD_W-1:0] = s.pins[MOD_W +: DEMOD_W];
      vec[CAT_TX][TX_W-1:0] = s.pins[MOD_W+DEMOD_W +: TX_W];
      vec[CAT_RX][RX_W-1:0] = s.pins[MOD_W+DEMOD_W+TX_W +: RX_W];
      vec[CAT_RX][RX_PATT_BIT] = patt_alarm;
      vec[CAT_RX][RX_FILL_BIT] = fill_alarm;
      vec[CAT_COM][COM_W-1:0] = s.pins[MOD_W+DEMOD_W+TX_W+RX_W +: COM_W];
      vec[CAT_COM][COM_CTRL_BIT] = s.ctrl_fault;
      vec[CAT_COM][COM_IFACE_BIT] = !s.pins[PIN_W-2] || !s.pins[PIN_W-1];
      vec[CAT_UNAVL][0] = s.unavl;
      for (int c = 0; c < NCAT; c++) begin
         chg[c] = (s.pwr == SFL_RUN) && (vec[c] != s.prev[c]);
         base[c] = clr_log ? '0 : s.cnt[c];
         rec[c] = chg[c] && (base[c] < SLOTS);
      end
   end

   always_comb begin
      next_s = s;
      // three stages; a bit moves only once stages two and three agree
      next_s.s1 = {iface_prog_ok, iface_present, common_fault, rx_fault, tx_fault,
                   demod_fault, mod_fault};
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.pins = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.pins);
      next_s.prev = vec;

      // one-second window for uncorrectable blocks
      next_s.sec_cnt = tick ? '0 : s.sec_cnt + 32'h1;
      if (tick) begin
         next_s.unavl = s.err_sec || (s.fec_fit && blk_uncorrectable);
         next_s.err_sec = 1'b0;
      end else if (s.fec_fit && blk_uncorrectable) begin
         next_s.err_sec = 1'b1;
      end

      unique case (s.pwr)
         SFL_PDOWN: begin
            next_s.retained = nv_tod;
            next_s.log[CAT_COM][0] = '{tod: nv_tod, vec: PDOWN_VEC};
            next_s.cnt[CAT_COM] = 4'h1;
            next_s.pwr = SFL_PUP;
         end
         SFL_PUP: begin
            next_s.log[CAT_COM][1] = '{tod: tod, vec: PUP_VEC};
            next_s.cnt[CAT_COM] = 4'h2;
            next_s.pwr = SFL_RUN;
         end
         SFL_RUN: begin
            for (int c = 0; c < NCAT; c++) begin
               next_s.cnt[c] = base[c];
               if (rec[c]) begin
                  next_s.log[c][base[c]] = '{tod: tod, vec: vec[c]};
                  next_s.cnt[c] = base[c] + 4'h1;
               end
            end
         end
         default: begin
            next_s.pwr = SFL_PDOWN;
         end
      endcase

      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         unique case (s.awaddr[AXI_AW-1:2])
            REG_CTRL[AXI_AW-1:2]: begin
               next_s.chk_en = wm_ctrl[CTRL_CHK_EN];
               next_s.fec_fit = wm_ctrl[CTRL_FEC];
               if (s.wstrb[0] && s.wdata[CTRL_CLR_CTRLF]) begin
                  next_s.ctrl_fault = 1'b0;
               end
            end
            REG_SEL[AXI_AW-1:2]: begin
               next_s.sel_slot = wm_sel[SEL_SLOT_LSB +: SLOT_W];
               next_s.sel_cat = wm_sel[SEL_CAT_LSB +: CAT_W];
            end
            REG_IRQ_ST[AXI_AW-1:2]: begin
               next_s.irq_st = s.irq_st & ~wm_clr[NCAT-1:0];
            end
            REG_IRQ_MASK[AXI_AW-1:2]: begin
               next_s.irq_mask = wm_mask[NCAT-1:0];
            end
            REG_ENT_TIME[AXI_AW-1:2], REG_ENT_VEC[AXI_AW-1:2], REG_COUNTS[AXI_AW-1:2],
            REG_ALARMS[AXI_AW-1:2]: begin
               next_s.bresp = RESP_OKAY;
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end
      // a new record beats a same-cycle write-one-to-clear
      next_s.irq_st = next_s.irq_st | rec;

      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         unique case (s_axi_araddr[AXI_AW-1:2])
            REG_CTRL[AXI_AW-1:2]: next_s.rdata = ctrl_reg;
            REG_SEL[AXI_AW-1:2]: next_s.rdata = sel_reg;
            REG_ENT_TIME[AXI_AW-1:2]: next_s.rdata = ent.tod;
            REG_ENT_VEC[AXI_AW-1:2]: next_s.rdata = 32'(ent.vec);
            REG_COUNTS[AXI_AW-1:2]: next_s.rdata = counts_reg;
            REG_IRQ_ST[AXI_AW-1:2]: next_s.rdata = 32'(s.irq_st);
            REG_IRQ_MASK[AXI_AW-1:2]: next_s.rdata = 32'(s.irq_mask);
            REG_ALARMS[AXI_AW-1:2]: next_s.rdata = {29'h0, s.unavl, fill_alarm, patt_alarm};
            default: begin
               next_s.rdata = '0;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // logs are zeroed here with the rest of the state; the counts mark them empty
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.pwr <= SFL_PDOWN;
         s.ctrl_fault <= 1'b1;
         s.irq_mask <= MASK_RST;
         // interface pins idle high; a low image would log a false module fault
         s.s1[PIN_W-2 +: 2] <= IFACE_IDLE;
         s.s2[PIN_W-2 +: 2] <= IFACE_IDLE;
         s.s3[PIN_W-2 +: 2] <= IFACE_IDLE;
         s.pins[PIN_W-2 +: 2] <= IFACE_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = !s.aw_got && !s.bvalid;
   assign s_axi_wready = !s.w_got && !s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign irq = |(s.irq_st & s.irq_mask);

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence q_boot;
      s.pwr == SFL_PDOWN ##1 s.pwr == SFL_PUP;
   endsequence

   sequence q_boot_done;
      s.pwr == SFL_RUN && s.cnt[CAT_COM] == 4'h2 && s.log[CAT_COM][0].tod == s.retained &&
      s.log[CAT_COM][0].vec == PDOWN_VEC && s.log[CAT_COM][1].vec == PUP_VEC;
   endsequence

   a_boot_entries: assert property (q_boot |=> q_boot_done)
      else $error("power entries not written to common slots 0 and 1");

   a_boot_stamp: assert property (s.pwr == SFL_PUP |=> s.log[CAT_COM][1].tod == $past(tod))
      else $error("power-up entry has wrong stamp");

   a_count_cap: assert property (s.cnt[CAT_MOD] <= SLOTS && s.cnt[CAT_RX] <= SLOTS)
      else $error("log count exceeds ten");

   a_full_hold: assert property (s.pwr == SFL_RUN && s.cnt[CAT_MOD] == SLOTS && !clr_log
      |=> s.cnt[CAT_MOD] == SLOTS && $stable(s.log[CAT_MOD]))
      else $error("full log changed");

   a_record_step: assert property (rec[CAT_MOD] && !clr_log
      |=> s.cnt[CAT_MOD] == $past(s.cnt[CAT_MOD]) + 4'h1)
      else $error("count did not advance on change");

   a_entry_stamp: assert property (rec[CAT_DEMOD] && base[CAT_DEMOD] == 4'h0
      |=> s.log[CAT_DEMOD][0].tod == $past(tod) &&
          s.log[CAT_DEMOD][0].vec == $past(vec[CAT_DEMOD]))
      else $error("entry stamp or vector wrong");

   a_same_stamp: assert property (rec[CAT_DEMOD] && rec[CAT_TX] && !clr_log &&
      s.cnt[CAT_DEMOD] == s.cnt[CAT_TX] ##1 1'b1
      |-> s.log[CAT_DEMOD][$past(s.cnt[CAT_DEMOD])].tod ==
          s.log[CAT_TX][$past(s.cnt[CAT_TX])].tod)
      else $error("simultaneous entries differ in stamp");

   a_clear_log: assert property (clr_log && !chg[CAT_RX] && s.pwr == SFL_RUN
      |=> s.cnt[CAT_RX] == 4'h0)
      else $error("clear left entries");

   a_empty_read: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[AXI_AW-1:2] == REG_ENT_VEC[AXI_AW-1:2] && s.sel_slot >= s.cnt[s.sel_cat]
      |=> s.rvalid && s.rdata == 32'h0)
      else $error("unused slot reads non-empty");

   a_fill_alarm: assert property (rxbuf_level < 16'h0067 |-> vec[CAT_RX][RX_FILL_BIT])
      else $error("empty buffer without fill alarm");

   a_patt_off: assert property (!s.chk_en |-> !vec[CAT_RX][RX_PATT_BIT])
      else $error("pattern alarm while checker off");

   a_unavl_tick: assert property ($rose(s.unavl) |-> $past(tick) && $past(s.fec_fit))
      else $error("unavailable second raised off the boundary");

   a_irq_set: assert property (rec[CAT_RX] |=> s.irq_st[CAT_RX])
      else $error("recorded entry left status clear");

   a_ctrl_boot: assert property (s.pwr == SFL_PUP |-> s.ctrl_fault)
      else $error("controller flag not set after power cycle");
endmodule

// ---- tb/sfl_logger_tb_top.sv ----
`timescale 1ns/1ps
module sfl_logger_tb_top;
   import sfl_pkg::*;
   logic core_clk = 0, arst_n = 0, iface_present = 1, iface_prog_ok = 1;
   logic prbs_locked = 0, blk_uncorrectable = 0;
   logic [MOD_W-1:0] mod_fault = '0;
   logic [DEMOD_W-1:0] demod_fault = '0;
   logic [TX_W-1:0] tx_fault = '0;
   logic [RX_W-1:0] rx_fault = '0;
   logic [COM_W-1:0] common_fault = '0;
   logic [TOD_W-1:0] tod = 32'h0000_0100, nv_tod = '0;
   logic [LVL_W-1:0] rxbuf_level = 16'h0200;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int mismatches = 0, cmp_count = 0, seed = 32'ha889;
   int lv_tab [7] = '{101, 102, 103, 512, 921, 922, 923};
   logic [1:0] ift [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
   // model state: expected log contents per category
   logic ctl_flag = 1, chk_en = 0;
   logic [15:0] prev [0:4];
   logic [47:0] lq [0:5][$];
   logic [31:0] d;
   logic [1:0] r;
   logic [47:0] e;
   logic [15:0] v;

   sfl_logger #(.SEC_CYCLES(100)) uut (
      .core_clk, .arst_n, .mod_fault, .demod_fault, .tx_fault, .rx_fault, .common_fault,
      .iface_present, .iface_prog_ok, .tod, .nv_tod, .rxbuf_level, .prbs_locked,
      .blk_uncorrectable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq
   );

   always #4 core_clk = ~core_clk;

   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // handshakes sampled on the falling edge: same value the next rising edge sees
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
      bit awt, wt, got;
      int n;
      got = 0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!got && n < 50) begin
         @(negedge core_clk);
         awt = s_axi_awvalid && s_axi_awready;
         wt = s_axi_wvalid && s_axi_wready;
         got = s_axi_bvalid === 1'b1;
         if (got) check(s_axi_bresp, er);
         @(posedge core_clk);
         if (awt) s_axi_awvalid <= 0;
         if (wt) s_axi_wvalid <= 0;
         n++;
      end
      s_axi_bready <= 0;
      if (!got) check(0, 1);
      @(posedge core_clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
      bit art, got;
      int n;
      got = 0;
      n = 0;
      rd = '0;
      rr = '0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!got && n < 50) begin
         @(negedge core_clk);
         art = s_axi_arvalid && s_axi_arready;
         got = s_axi_rvalid === 1'b1;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge core_clk);
         if (art) s_axi_arvalid <= 0;
         n++;
      end
      s_axi_rready <= 0;
      if (!got) check(0, 1);
      @(posedge core_clk);
   endtask

   function automatic logic [15:0] expv(input int c);
      int lv;
      logic fill;
      lv = rxbuf_level;
      fill = (lv * PCT_FULL < RXBUF_DEPTH * FILL_LO_PCT) ||
             (lv * PCT_FULL > RXBUF_DEPTH * FILL_HI_PCT);
      case (c)
         0: return {8'h00, mod_fault};
         1: return {10'h000, demod_fault};
         2: return {9'h000, tx_fault};
         3: return {6'h00, fill, chk_en & ~prbs_locked, rx_fault};
         default: return {10'h000, ~(iface_present & iface_prog_ok), ctl_flag, common_fault};
      endcase
   endfunction

   // inputs held still long enough for the pin synchronisers to settle
   task automatic settle();
      logic [15:0] nv;
      repeat (8) @(posedge core_clk);
      for (int c = 0; c < 5; c++) begin
         nv = expv(c);
         if (nv !== prev[c]) begin
            if (lq[c].size() < 10) lq[c].push_back({tod, nv});
            prev[c] = nv;
         end
      end
   endtask

   task automatic rd_entry(input int c, input int s, output logic [47:0] ent);
      logic [31:0] t, vv;
      logic [1:0] rr;
      axi_wr(REG_SEL, (c << SEL_CAT_LSB) | s, RESP_OKAY);
      axi_rd(REG_ENT_TIME, t, rr);
      axi_rd(REG_ENT_VEC, vv, rr);
      ent = {t, vv[15:0]};
   endtask

   task automatic chk_log(input int c);
      logic [31:0] cnt;
      logic [1:0] rr;
      logic [47:0] ent;
      axi_rd(REG_COUNTS, cnt, rr);
      check(cnt[4*c +: 4], lq[c].size());
      for (int s = 0; s < 10; s++) begin
         rd_entry(c, s, ent);
         check(ent, s < lq[c].size() ? lq[c][s] : 48'h0);
      end
   endtask

   task automatic do_reset(input logic [31:0] nv);
      arst_n <= 0;
      nv_tod <= nv;
      {mod_fault, demod_fault, tx_fault, rx_fault, common_fault} <= '0;
      iface_present <= 1;
      iface_prog_ok <= 1;
      rxbuf_level <= 16'h0200;
      prbs_locked <= 0;
      ctl_flag = 1;
      chk_en = 0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1;
      repeat (8) @(posedge core_clk);
      for (int c = 0; c < 6; c++) lq[c].delete();
      for (int c = 0; c < 5; c++) prev[c] = expv(c);
      lq[4].push_back({nv, PDOWN_VEC});
      lq[4].push_back({tod, PUP_VEC});
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      do_reset(32'h1234_5678);
      axi_rd(REG_CTRL, d, r);
      check(d[3:2], 2'b00);
      axi_rd(REG_IRQ_MASK, d, r);
      check(d, MASK_RST);
      check(irq, 0);
      for (int c = 0; c < 6; c++) chk_log(c);
      axi_rd(8'h20, d, r);
      check({r, d}, {RESP_SLVERR, 32'h0});
      axi_wr(8'h24, 32'hffff_ffff, RESP_SLVERR);
      rd_entry(6, 0, e);
      check(e, 48'h0);
      axi_wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
      // eleventh change must be dropped
      for (int i = 0; i < 11; i++) begin
         v = $random(seed);
         if (v[7:0] == mod_fault) v[0] = ~v[0];
         mod_fault <= v[7:0];
         tod <= $random(seed);
         settle();
         check(irq, 1);
      end
      chk_log(0);
      axi_wr(REG_IRQ_ST, 32'h3f, RESP_OKAY);
      check(irq, 0);
      v = $random(seed);
      tod <= $random(seed);
      demod_fault <= v[5:0] | 6'h01;
      tx_fault <= v[12:6] | 7'h01;
      rx_fault <= v[7:0] | 8'h01;
      settle();
      for (int c = 1; c < 4; c++) chk_log(c);
      foreach (lv_tab[i]) begin
         rxbuf_level <= lv_tab[i][15:0];
         settle();
         v = expv(3);
         axi_rd(REG_ALARMS, d, r);
         check(d[1], v[9]);
      end
      for (int i = 0; i < 3; i++) begin
         chk_en = i > 0;
         prbs_locked <= i > 1;
         axi_wr(REG_CTRL, {chk_en, 2'b00}, RESP_OKAY);
         settle();
         v = expv(3);
         axi_rd(REG_ALARMS, d, r);
         check(d[0], v[8]);
      end
      chk_log(3);
      ctl_flag = 0;
      axi_wr(REG_CTRL, 32'h6, RESP_OKAY);
      settle();
      chk_log(4);
      axi_wr(REG_CTRL, 32'h5, RESP_OKAY);
      for (int c = 0; c < 6; c++) lq[c].delete();
      axi_rd(REG_COUNTS, d, r);
      check(d, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {iface_present, iface_prog_ok} <= ift[i];
         common_fault <= i[3:0];
         settle();
      end
      chk_log(4);
      chk_log(0);
      // first pass not fitted: nothing may be logged
      for (int i = 0; i < 2; i++) begin
         axi_wr(REG_CTRL, {i[0], 3'b100}, RESP_OKAY);
         blk_uncorrectable <= 1;
         @(posedge core_clk);
         blk_uncorrectable <= 0;
         repeat (250) @(posedge core_clk);
         axi_rd(REG_COUNTS, d, r);
         check(d[23:20], 2 * i);
      end
      rd_entry(5, 1, e);
      check(e, {tod, 16'h0});
      rd_entry(5, 0, e);
      check(e[47:16], tod);
      check(e[15:0], 16'h0001);
      do_reset(32'h0bad_cafe);
      chk_log(4);
      chk_log(3);
      finish_test();
   end
endmodule
